// file: src/boot_restart_control.sv
// Start-up, power-fail, restart and program-load control for a CPU board.
// Assumes straps, monitors and console inputs synchronous to pclk.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "boot_restart_map.svh"

module boot_restart_control
  import boot_restart_pkg::*;
#(
  parameter int PF_HOLD_CYC = `PF_HOLD_MS * `CLK_KHZ
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             irq,
  // Straps
  input  wire logic        jumper_word_enable,
  input  wire logic        select_load_device_code,
  input  wire logic        select_start_address,
  input  wire logic        no_battery_restart_inhibit,
  input  wire logic        boot_rom_enable,
  input  wire logic [15:0] jumper_word,
  input  wire logic [3:0]  mem_bank_jumper,
  // Monitors and console
  input  wire logic        power_ok,
  input  wire logic        power_failing,
  input  wire logic        battery_ok,
  input  wire logic        console_start,
  input  wire logic        console_load,
  input  wire logic        console_lock,
  // Processor side
  output logic             cpu_reset,
  output logic             cpu_run,
  output logic             pf_irq,
  output logic             takeover,
  output logic [15:0]      start_addr,
  output logic [5:0]       load_dev_code,
  output logic             load_dev_valid,
  output logic             clk_ph1,
  output logic             clk_ph2,
  // Memory side
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  output logic             onboard_sel,
  output logic [11:0]      onboard_addr,
  output logic             rom_ack,
  output logic [5:0]       rom_addr,
  output logic [15:0]      rom_data,
  output logic             mem_wr,
  output logic [15:0]      mem_wr_addr,
  output logic [15:0]      mem_wr_data
);

  ////////////////////////////////////////////////////////////////////////
  boot_state_e state_reg, state_next;
  logic [19:0] cnt_reg;
  logic [3:0]  ctrl_reg;
  logic [3:0]  int_stat_reg;
  logic [3:0]  int_mask_reg;
  logic [3:0]  ev;
  logic        jw_en_reg, sel_ld_reg, sel_st_reg, inhib_reg, rom_en_reg;
  logic [15:0] jw_reg;
  logic [3:0]  bank_reg;
  logic        con_start_reg, con_load_reg, con_lock_reg;
  logic        pfail_reg, batt_reg;
  logic        start_cmd_reg, load_cmd_reg;
  logic [4:0]  copy_idx_reg;
  logic [1:0]  ph_reg;
  logic        wr_en, rd_en, rom_wr;
  word_t       rom [64];
  logic        st_valid, ld_valid, bad_cfg;
  logic        go, load_go, ar_allow;

  ////////////////////////////////////////////////////////////////////////
  // Straps caught only while the processor is held in cold reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jw_en_reg  <= 1'b0;
      sel_ld_reg <= 1'b0;
      sel_st_reg <= 1'b0;
      inhib_reg  <= 1'b0;
      rom_en_reg <= 1'b0;
      jw_reg     <= 16'h0000;
      bank_reg   <= 4'h0;
    end else if (state_reg == ST_COLD) begin
      jw_en_reg  <= jumper_word_enable;
      sel_ld_reg <= select_load_device_code;
      sel_st_reg <= select_start_address;
      inhib_reg  <= no_battery_restart_inhibit;
      rom_en_reg <= boot_rom_enable;
      jw_reg     <= jumper_word;
      bank_reg   <= mem_bank_jumper;
    end
  end

  // Both selects fitted is illegal; treat as neither
  assign bad_cfg  = jw_en_reg && sel_ld_reg && sel_st_reg;
  assign st_valid = jw_en_reg && sel_st_reg && !sel_ld_reg;
  assign ld_valid = jw_en_reg && sel_ld_reg && !sel_st_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_addr     <= 16'h0000;
      load_dev_code  <= 6'h00;
      load_dev_valid <= 1'b0;
    end else begin
      start_addr     <= st_valid ? jw_reg : 16'h0000;
      load_dev_code  <= ld_valid ? jw_reg[5:0] : 6'h00;
      load_dev_valid <= ld_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Console and monitor buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_start_reg <= 1'b0;
      con_load_reg  <= 1'b0;
      con_lock_reg  <= 1'b0;
      pfail_reg     <= 1'b0;
      batt_reg      <= 1'b0;
    end else begin
      con_start_reg <= console_start;
      con_load_reg  <= console_load;
      con_lock_reg  <= console_lock;
      pfail_reg     <= power_failing;
      batt_reg      <= battery_ok;
    end
  end

  assign go      = con_start_reg || start_cmd_reg ||
                   ctrl_reg[`CTRL_SELF_START];
  assign load_go = (con_load_reg || load_cmd_reg) && rom_en_reg;
  // Locked console or dead battery with inhibit fitted blocks restart
  assign ar_allow = ctrl_reg[`CTRL_AR_EN] && !con_lock_reg &&
                    !(inhib_reg && !batt_reg) && !bad_cfg;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_COLD:
        if (power_ok && cnt_reg == 20'(`COLD_HOLD_CYC - 1))
          state_next = ST_HALT;
      ST_HALT:
        if (pfail_reg) state_next = ST_DOWN;
        else if (load_go) state_next = ST_LOAD;
        else if (go) state_next = ST_RUN;
      ST_RUN:
        if (pfail_reg) state_next = ST_PFWARN;
      ST_PFWARN:
        if (cnt_reg == 20'(PF_HOLD_CYC - 1)) state_next = ST_DOWN;
      ST_DOWN:
        if (power_ok && !pfail_reg)
          state_next = ar_allow ? ST_AUTORS : ST_HALT;
      ST_AUTORS:
        state_next = ST_RUN;
      // One cycle past the last word so it is written under takeover
      ST_LOAD:
        if (copy_idx_reg == 5'(`LOAD_LAST - `LOAD_FIRST + 16'h0001))
          state_next = ST_RUN;
      default:
        state_next = ST_COLD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_reg <= ST_COLD;
    else          state_reg <= state_next;
  end

  // Shared cycle counter for cold hold and power-fail window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 20'h00000;
    else if (state_next != state_reg) cnt_reg <= 20'h00000;
    else if (state_reg == ST_COLD && cnt_reg != 20'(`COLD_HOLD_CYC - 1))
      cnt_reg <= cnt_reg + 20'h00001;
    else if (state_reg == ST_PFWARN) cnt_reg <= cnt_reg + 20'h00001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset <= 1'b1;
      cpu_run   <= 1'b0;
      pf_irq    <= 1'b0;
      takeover  <= 1'b0;
    end else begin
      cpu_reset <= state_next inside {ST_COLD, ST_DOWN};
      cpu_run   <= state_next inside {ST_RUN, ST_PFWARN};
      pf_irq    <= state_next == ST_PFWARN;
      takeover  <= state_next inside {ST_AUTORS, ST_LOAD};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bootstrap copy, one word a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      copy_idx_reg <= 5'h00;
      mem_wr       <= 1'b0;
      mem_wr_addr  <= 16'h0000;
      mem_wr_data  <= 16'h0000;
    end else begin
      mem_wr <= state_reg == ST_LOAD && state_next == ST_LOAD;
      mem_wr_addr <= `LOAD_FIRST + 16'(copy_idx_reg);
      mem_wr_data <= rom[copy_idx_reg];
      if (state_reg == ST_LOAD) copy_idx_reg <= copy_idx_reg + 5'h01;
      else copy_idx_reg <= 5'h00;
    end
  end

  // Load ROM: CPU reads in window, contents loaded over APB
  assign rom_wr = wr_en && paddr[11:8] == `ROM_WIN_PAGE;
  for (genvar i = 0; i < 64; i++) begin : g_rom
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rom[i] <= 16'h0000;
      else if (rom_wr && paddr[7:2] == 6'(i)) rom[i] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_ack  <= 1'b0;
      rom_addr <= 6'h00;
      rom_data <= 16'h0000;
    end else begin
      rom_ack  <= rom_en_reg && mem_rd &&
                  mem_addr[15:6] == `ROM_BASE >> 6;
      rom_addr <= mem_addr[5:0];
      rom_data <= rom[mem_addr[5:0]];
    end
  end

  // On-board RAM bank decode; top bank is allowed but discouraged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onboard_sel  <= 1'b0;
      onboard_addr <= 12'h000;
    end else begin
      onboard_sel  <= mem_addr[15:12] == bank_reg;
      onboard_addr <= mem_addr[11:0];
    end
  end

  // Two-phase clock: gaps between phases keep them from overlapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg  <= 2'h0;
      clk_ph1 <= 1'b0;
      clk_ph2 <= 1'b0;
    end else begin
      ph_reg  <= ph_reg + 2'h1;
      clk_ph1 <= ph_reg == 2'h0;
      clk_ph2 <= ph_reg == 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !(paddr[11:8] == `ROM_WIN_PAGE ||
                   paddr inside {`CTRL_OFS, `STATUS_OFS, `INT_STAT_OFS,
                                 `INT_MASK_OFS, `JUMPER_OFS});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= `CTRL_RST_VAL;
      start_cmd_reg <= 1'b0;
      load_cmd_reg  <= 1'b0;
      int_mask_reg  <= 4'h0;
    end else begin
      start_cmd_reg <= wr_en && paddr == `CTRL_OFS &&
                       pwdata[`CTRL_START];
      load_cmd_reg  <= wr_en && paddr == `CTRL_OFS && pwdata[`CTRL_LOAD];
      if (wr_en && paddr == `CTRL_OFS) ctrl_reg <= {2'b00, pwdata[1:0]};
      if (wr_en && paddr == `INT_MASK_OFS) int_mask_reg <= pwdata[3:0];
    end
  end

  assign ev[`EV_PFAIL]     = state_next == ST_PFWARN && state_reg == ST_RUN;
  assign ev[`EV_PRETURN]   = state_reg == ST_DOWN && state_next != ST_DOWN;
  assign ev[`EV_LOAD_DONE] = state_reg == ST_LOAD && state_next == ST_RUN;
  assign ev[`EV_BAD_CFG]   = bad_cfg;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_stat_reg <= 4'h0;
    else if (wr_en && paddr == `INT_STAT_OFS)
      int_stat_reg <= (int_stat_reg & ~pwdata[3:0]) | ev;
    else int_stat_reg <= int_stat_reg | ev;
  end

  assign irq = |(int_stat_reg & int_mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (rd_en) begin
      prdata <= 32'h00000000;
      if (paddr[11:8] == `ROM_WIN_PAGE)
        prdata <= {16'h0000, rom[paddr[7:2]]};
      else case (paddr)
        `CTRL_OFS:     prdata <= {28'h0000000, ctrl_reg};
        `STATUS_OFS:   prdata <= {22'h000000, bad_cfg, batt_reg,
                                  con_lock_reg, pf_irq, cpu_run, cpu_reset,
                                  1'b0, 3'(state_reg)};
        `INT_STAT_OFS: prdata <= {28'h0000000, int_stat_reg};
        `INT_MASK_OFS: prdata <= {28'h0000000, int_mask_reg};
        `JUMPER_OFS:   prdata <= {7'h00, bank_reg, rom_en_reg, inhib_reg,
                                  sel_st_reg, sel_ld_reg, jw_en_reg, jw_reg};
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_cold_reset: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_COLD |-> cpu_reset && !cpu_run)
    else $error("processor not held in reset during cold start");

  a_no_self_run: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_HALT && !go && !load_go |=> state_reg != ST_RUN)
    else $error("processor started without a start command");

  a_pf_warn: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pf_irq) |-> !cpu_reset [*8])
    else $error("power-fail warning not followed by run time");

  a_pf_raise: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_RUN && pfail_reg |=> pf_irq)
    else $error("power-fail interrupt not raised");

  a_jw_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !jw_en_reg |=> start_addr == 16'h0000 && !load_dev_valid)
    else $error("jumper word used while disabled");

  a_dev_code: assert property (@(posedge pclk) disable iff (!presetn)
    ld_valid |=> load_dev_code == $past(jw_reg[5:0]))
    else $error("load device code wrong");

  a_rom_gate: assert property (@(posedge pclk) disable iff (!presetn)
    mem_rd && mem_addr < `ROM_BASE |=> !rom_ack)
    else $error("boot ROM answered outside its window");

  a_copy_range: assert property (@(posedge pclk) disable iff (!presetn)
    mem_wr |-> mem_wr_addr >= `LOAD_FIRST && mem_wr_addr <= `LOAD_LAST)
    else $error("bootstrap write outside target range");

  a_no_bat_inh: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_DOWN && inhib_reg && !batt_reg |=> state_reg != ST_AUTORS)
    else $error("auto-restart despite inhibit without battery");

  a_bank_dec: assert property (@(posedge pclk) disable iff (!presetn)
    onboard_sel |-> $past(mem_addr[15:12]) == $past(bank_reg))
    else $error("on-board memory selected outside its bank");

  a_phases: assert property (@(posedge pclk) disable iff (!presetn)
    clk_ph1 |=> !clk_ph2 ##1 clk_ph2)
    else $error("clock phases overlap or out of order");

endmodule : boot_restart_control
`default_nettype wire

// file: src/boot_restart_map.svh
// Constants for the boot and restart controller: offsets, fields, timing.
// Assumes APB byte addressing, 32-bit data, pclk at 100 MHz.
`ifndef BOOT_RESTART_MAP_SVH
`define BOOT_RESTART_MAP_SVH

`define CTRL_OFS        12'h000
`define STATUS_OFS      12'h004
`define INT_STAT_OFS    12'h008
`define INT_MASK_OFS    12'h00C
`define JUMPER_OFS      12'h010
`define ROM_WIN_PAGE    4'h1

`define CTRL_SELF_START 0
`define CTRL_AR_EN      1
`define CTRL_START      2
`define CTRL_LOAD       3
`define CTRL_RST_VAL    4'h0

`define EV_PFAIL        0
`define EV_PRETURN      1
`define EV_LOAD_DONE    2
`define EV_BAD_CFG      3

`define ROM_BASE        16'h7FC0
`define LOAD_FIRST      16'h0002
`define LOAD_LAST       16'h001F
`define LOAD_START      16'h0002

`define PF_HOLD_MS      2
`define CLK_KHZ         100000
`define COLD_HOLD_CYC   16

`endif

// file: src/boot_restart_pkg.sv
// Types shared by the boot and restart controller.
// Assumes nothing beyond the map header.
`default_nettype none
package boot_restart_pkg;
  typedef enum logic [2:0] {
    ST_COLD, ST_HALT, ST_RUN, ST_PFWARN, ST_DOWN, ST_AUTORS, ST_LOAD
  } boot_state_e;
  typedef logic [15:0] word_t;
endpackage : boot_restart_pkg
`default_nettype wire

// file: verif/boot_restart_control_bench.sv
// Bench for boot_restart_control: cold start, load, power fail, straps.
// Assumes pwr_console_model on the far side and zero-wait APB.
`timescale 1ns/1ns
`default_nettype none
module boot_restart_control_bench import boot_restart_pkg::*; ();
  localparam int PF = 40;
  localparam int TO = 400;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, r;
  logic pready, pslverr, irq, rerr, battery_ok = 0, console_lock = 0;
  logic jumper_word_enable = 0, select_load_device_code = 0;
  logic select_start_address = 0, no_battery_restart_inhibit = 0;
  logic boot_rom_enable = 0, mem_rd = 0, mains_on = 0;
  logic press_start = 0, press_load = 0, seen_take = 0, ar, lk;
  logic [15:0] jumper_word = '0, mem_addr = '0, w;
  logic [3:0] mem_bank_jumper = '0, bank, mon;
  logic power_ok, power_failing, console_start, console_load;
  logic cpu_reset, cpu_run, pf_irq, takeover, load_dev_valid;
  logic clk_ph1, clk_ph2, onboard_sel, rom_ack, mem_wr;
  logic [15:0] start_addr, rom_data, mem_wr_addr, mem_wr_data;
  logic [5:0] load_dev_code, rom_addr, s;
  logic [11:0] onboard_addr;
  word_t rom [64];
  int error_cnt = 0, check_count = 0, seed = 32'hA62E916C, n, gap = 0;

  always #5 pclk = ~pclk;
  assign mon = {takeover, pf_irq, cpu_reset, cpu_run};

  boot_restart_control #(.PF_HOLD_CYC(PF)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .irq, .jumper_word_enable, .select_load_device_code,
    .select_start_address, .no_battery_restart_inhibit, .boot_rom_enable,
    .jumper_word, .mem_bank_jumper, .power_ok, .power_failing, .battery_ok,
    .console_start, .console_load, .console_lock, .cpu_reset, .cpu_run,
    .pf_irq, .takeover, .start_addr, .load_dev_code, .load_dev_valid,
    .clk_ph1, .clk_ph2, .mem_addr, .mem_rd, .onboard_sel, .onboard_addr,
    .rom_ack, .rom_addr, .rom_data, .mem_wr, .mem_wr_addr, .mem_wr_data);

  pwr_console_model #(.FAIL_LAG(60)) far_side (
    .pclk, .mains_on, .press_start, .press_load, .power_ok, .power_failing,
    .console_start, .console_load);

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input logic [47:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : chk

  task automatic apb(input logic is_wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < TO);
    rdat    = prdata;
    rerr    = pslverr;
    chk(pready, 1'b1, "pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rdat, e, "read");
  endtask : rd

  task automatic wait_sig(input int k, input logic v);
    n = 0;
    #1;
    while (mon[k] !== v && n < TO) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(mon[k], v, "wait");
  endtask : wait_sig

  task automatic pulse(input logic ld);
    @(posedge pclk);
    if (ld) press_load <= 1'b1;
    else press_start <= 1'b1;
    @(posedge pclk);
    press_load  <= 1'b0;
    press_start <= 1'b0;
  endtask : pulse

  task automatic cfg(input logic [5:0] st, input logic [15:0] wd);
    @(posedge pclk);
    {jumper_word_enable, select_load_device_code, select_start_address,
     no_battery_restart_inhibit, boot_rom_enable, battery_ok} <= st;
    jumper_word     <= wd;
    mem_bank_jumper <= bank;
    presetn         <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : cfg

  task automatic mchk(input logic [15:0] a, input logic ack,
                      input logic [15:0] d);
    @(posedge pclk);
    mem_addr <= a;
    mem_rd   <= 1'b1;
    @(posedge pclk);
    mem_rd   <= 1'b0;
    #1;
    chk(rom_ack, ack, "rom ack");
    if (ack) chk({rom_addr, rom_data}, {a[5:0], d}, "rom");
    chk(onboard_sel, a[15:12] == bank, "bank");
    if (onboard_sel) chk(onboard_addr, a[11:0], "bank addr");
  endtask : mchk

  // Fail, drop to reset, restore; restart outcome checked last
  task automatic pcycle(input logic rs);
    int k;
    @(posedge pclk);
    mains_on <= 1'b0;
    wait_sig(2, 1'b1);
    k = 0;
    while (pf_irq === 1'b1 && cpu_run === 1'b1 && k < TO) begin
      @(posedge pclk);
      #1;
      k++;
    end
    chk(k >= PF, 1'b1, "warn span");
    wait_sig(1, 1'b1);
    seen_take = 1'b0;
    @(posedge pclk);
    mains_on <= 1'b1;
    wait_sig(1, 1'b0);
    repeat (6) @(posedge pclk);
    #1;
    chk(cpu_run, rs, "restart");
    if (rs) chk(seen_take, 1'b1, "takeover");
  endtask : pcycle

  function automatic logic [22:0] exp_st(input logic e, l, t,
                                        input logic [15:0] wd);
    return {e && l && !t, (e && l && !t) ? wd[5:0] : 6'h00,
            (e && t && !l) ? wd : 16'h0000};
  endfunction : exp_st

  function automatic logic exp_rs(input logic a, k, i, b, e, l, t);
    return a && !k && !(i && !b) && !(e && l && t);
  endfunction : exp_rs

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) if (takeover === 1'b1) seen_take = 1'b1;

  always @(posedge pclk) begin
    #1;
    if (presetn !== 1'b1) gap = 0;
    else begin
      chk(clk_ph1 & clk_ph2, 1'b0, "phase overlap");
      if (clk_ph1 === 1'b1) begin
        if (gap != 0) chk(gap, 4, "phase period");
        gap = 1;
      end else if (gap != 0) gap++;
    end
  end

  // Whole run is about a thousand cycles
  initial begin
    #300000;
    error_cnt++;
    results();
  end

  initial begin
    bank = 4'h2;
    w = 16'($random(seed));
    cfg(6'b101011, w);
    repeat (20) @(posedge pclk);
    #1;
    chk({cpu_reset, cpu_run}, 2'b10, "cold hold");
    rd(12'h004, 32'h0000_0110);
    @(posedge pclk);
    mains_on <= 1'b1;
    wait_sig(1, 1'b0);
    repeat (8) @(posedge pclk);
    #1;
    chk(cpu_run, 1'b0, "no self start");
    chk({load_dev_valid, load_dev_code, start_addr},
        exp_st(1, 0, 1, w), "straps");
    rd(12'h010, {7'h00, 4'h2, 5'b10101, w});
    console_lock <= 1'b1;
    rd(12'h004, 32'h0000_0181);
    console_lock <= 1'b0;
    apb(1'b0, 12'h020, '0);
    chk(rerr, 1'b1, "unmapped");
    apb(1'b1, 12'h00C, 32'h0000_0005);
    rd(12'h00C, 32'h0000_0005);
    $display("test cold done");
    for (int i = 0; i < 64; i++) begin
      rom[i] = (i < 30 || i == 63) ? 16'($random(seed)) : 16'h0000;
      if (rom[i] != 0) apb(1'b1, 12'(12'h100 + 4 * i), {16'h0000, rom[i]});
    end
    pulse(1'b1);
    n = 0;
    #1;
    while (mem_wr !== 1'b1 && n < TO) begin
      @(posedge pclk);
      #1;
      n++;
    end
    for (int i = 0; i < 30; i++) begin
      chk({takeover, mem_wr, mem_wr_addr, mem_wr_data},
          {2'b11, 16'(i + 2), rom[i]}, "copy");
      @(posedge pclk);
      #1;
    end
    chk(mem_wr, 1'b0, "copy end");
    wait_sig(0, 1'b1);
    mchk(16'h7FC0, 1'b1, rom[0]);
    mchk(16'h7FFF, 1'b1, rom[63]);
    mchk(16'h7FBF, 1'b0, 16'h0000);
    mchk({bank, w[11:0]}, 1'b0, 16'h0000);
    mchk({4'h3, w[11:0]}, 1'b0, 16'h0000);
    chk(irq, 1'b1, "load irq");
    apb(1'b1, 12'h00C, 32'h0000_0000);
    #1;
    chk(irq, 1'b0, "masked");
    apb(1'b1, 12'h008, 32'h0000_0004);
    rd(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0002);
    $display("test load done");
    pcycle(1'b1);
    rd(12'h008, 32'h0000_0003);
    chk(irq, 1'b1, "fail irq");
    apb(1'b1, 12'h008, 32'h0000_0001);
    #1;
    chk(irq, 1'b0, "irq cleared");
    $display("test power fail done");
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      bank = {2'b00, r[1:0]};
      s = r[7:2];
      if (s[4] && s[3]) s[3] = 1'b0;
      if (k == 0) s = 6'b111011;
      if (k == 1) s = 6'b100100;
      if (k == 2) s[5] = 1'b0;
      if (k == 3) s[4:3] = 2'b00;
      ar = (k < 2) ? 1'b1 : r[8];
      lk = (k < 2) ? 1'b0 : r[9];
      console_lock <= lk;
      cfg(s, r[31:16]);
      wait_sig(1, 1'b0);
      chk({load_dev_valid, load_dev_code, start_addr},
          exp_st(s[5], s[4], s[3], r[31:16]), "straps");
      if (!s[1]) begin
        pulse(1'b1);
        repeat (6) @(posedge pclk);
        #1;
        chk(cpu_run, 1'b0, "load refused");
      end
      rd(12'h008, {28'h0, k == 0, 3'h0});
      apb(1'b1, 12'h000, {29'h0, k[0], ar, k == 4});
      rd(12'h000, {30'h0, ar, k == 4});
      if (!k[0] && k != 4) pulse(1'b0);
      wait_sig(0, 1'b1);
      if (k == 4) apb(1'b1, 12'h000, {30'h0, ar, 1'b0});
      pcycle(exp_rs(ar, lk, s[2], s[0], s[5], s[4], s[3]));
      $display("test strap set %0d done", k);
    end
    results();
  end
endmodule : boot_restart_control_bench
`default_nettype wire

// file: verif/pwr_console_model.sv
// Far-side model: supply monitors and console buttons of the board.
// Assumes bench commands change just after rising pclk edges.
`timescale 1ns/1ns
`default_nettype none
module pwr_console_model #(
  parameter int FAIL_LAG = 60
) (
  // Clock and bench commands
  input  wire logic pclk,
  input  wire logic mains_on,
  input  wire logic press_start,
  input  wire logic press_load,
  // Monitor and console lines
  output var logic  power_ok,
  output var logic  power_failing,
  output var logic  console_start,
  output var logic  console_load
);
  int lag = 0;

  initial begin
    power_ok      = 1'b0;
    power_failing = 1'b0;
    console_start = 1'b0;
    console_load  = 1'b0;
  end

  // Supply sags, then stays up long enough for the warning window
  always @(posedge pclk) begin
    console_start <= press_start;
    console_load  <= press_load;
    if (mains_on) begin
      power_ok      <= 1'b1;
      power_failing <= 1'b0;
      lag           <= 0;
    end else if (power_ok) begin
      power_failing <= 1'b1;
      lag           <= lag + 1;
      if (lag >= FAIL_LAG) power_ok <= 1'b0;
    end else begin
      power_failing <= 1'b0;
    end
  end
endmodule : pwr_console_model
`default_nettype wire
